// [verilog/tts_regs.svh]
// Register offsets, field positions and reset values of the thermal readout.
`ifndef TTS_REGS_SVH
`define TTS_REGS_SVH

// Byte addresses inside the memory-mapped window.
`define TTS_STATUS_LO_ADDR 16'h1044
`define TTS_STATUS_HI_ADDR 16'h1045
`define TTS_COUNT_ADDR 16'h1046
`define TTS_OFFSET_ADDR 16'h1047

// Bit positions inside the 16-bit status register.
`define TTS_AUX0_BIT 0
`define TTS_AUX1_BIT 1
`define TTS_AUX2_BIT 2
`define TTS_AUX3_BIT 3
`define TTS_HOT_BIT 4
`define TTS_CAT_BIT 5
`define TTS_VALID_BIT 10

// Reset values and limits.
`define TTS_STATUS_RESET 16'h0000
`define TTS_COUNT_RESET 8'hFF
`define TTS_OFFSET_RESET 8'h00
`define TTS_COUNT_MAX 8'hFF
`define TTS_BYTE_ZERO 8'h00
`define TTS_TRIPS_ZERO 6'h00

`endif

// [verilog/tts_pkg.sv]
// Types shared by the thermal readout and its surroundings.
`default_nettype none
package tts_pkg;

  // Phase of the thermometer conversion, one-hot.
  typedef enum logic [2:0] {
    TTS_OFF = 3'h1,
    TTS_CONVERT = 3'h2,
    TTS_VALID = 3'h4
  } tts_phase_type;

  // One access to the register window.
  typedef struct packed {
    logic [15:0] addr;
    logic write;
    logic read;
    logic [7:0] wdata;
  } tts_bus_req_type;

  // Read answer from the register window.
  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
  } tts_bus_rsp_type;

  // Signals from the sensor converter.
  typedef struct packed {
    logic [7:0] rawCount;
    logic sampleToggle;
    logic enable;
    logic inRange;
    logic converged;
  } tts_sensor_type;

  // Trip thresholds in adjusted reading units.
  typedef struct packed {
    logic [7:0] catastrophic;
    logic [7:0] hot;
    logic [7:0] aux3;
    logic [7:0] aux2;
    logic [7:0] aux1;
    logic [7:0] aux0;
  } tts_threshold_type;

  // Whole state of the readout.
  typedef struct packed {
    tts_sensor_type syncOne;
    tts_sensor_type syncTwo;
    logic toggleSeen;
    tts_phase_type phase;
    logic [7:0] count;
    logic [7:0] offset;
    logic [5:0] trips;
    logic [7:0] rdata;
    logic rvalid;
  } tts_state_type;

endpackage
`default_nettype wire

// [verilog/tts_thermal_readout.sv]
// Register-visible trip status, reading and offset of the thermal sensor.
//
// Overview of operation
// - Status bit 4 shows reading above hot.
// - Status bit 3 shows reading above aux3.
// - Status bit 2 shows reading above aux2.
// - Status bit 1 shows reading above aux1.
// - Status bit 0 shows aux0; flags reset zero.
// - Read-only reading register, meaningful while valid.
// - Reading is straight binary, resets to FFh.
// - Read-write offset register resetting to zero.
// - Offset is added to raw count.
// - Status bit 10 set only after convergence.
// - Status bit 5 shows reading above catastrophic.
`include "tts_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tts_thermal_readout (
  // Clock and synchronous reset.
  input wire logic clk,
  input wire logic reset,
  // Register window access.
  input wire tts_pkg::tts_bus_req_type busReq,
  output var tts_pkg::tts_bus_rsp_type busRsp,
  // Sensor converter, asynchronous to clk.
  input wire tts_pkg::tts_sensor_type sensorIn,
  // Thresholds from the trip point registers.
  input wire tts_pkg::tts_threshold_type tripLimits,
  // Status and reading for the throttling logic.
  output logic [15:0] thermalStatus,
  output logic [7:0] thermometerCount
);

  tts_pkg::tts_state_type state_reg;
  tts_pkg::tts_state_type state_next;
  logic sampleEdge;
  logic phaseValid;
  logic [15:0] statusWord;

  // Adds the offset to the raw count and clips at the top of the range.
  function automatic logic [7:0] applyOffset(
    input logic [7:0] raw,
    input logic [7:0] offs
  );
    logic [8:0] sum;
    sum = {1'h0, raw} + {1'h0, offs};
    applyOffset = sum[8] ? `TTS_COUNT_MAX : sum[7:0];
  endfunction

  // A flag trips only on a valid reading strictly above its limit.
  function automatic logic tripAbove(
    input logic live,
    input logic [7:0] reading,
    input logic [7:0] limit
  );
    tripAbove = live && (reading > limit);
  endfunction

  // A new conversion is flagged by a change of the synchronised toggle.
  assign sampleEdge = state_reg.syncTwo.sampleToggle ^ state_reg.toggleSeen;
  assign phaseValid = (state_reg.phase == tts_pkg::TTS_VALID);

  // Assembles the status word; reserved bits read as zero.
  always_comb begin
    statusWord = `TTS_STATUS_RESET;
    statusWord[`TTS_VALID_BIT] = phaseValid;
    statusWord[`TTS_CAT_BIT:`TTS_AUX0_BIT] = state_reg.trips;
  end

  // Computes the next state of the whole readout.
  always_comb begin
    state_next = state_reg;
    // Two flip-flops on every converter signal before any use.
    state_next.syncOne = sensorIn;
    state_next.syncTwo = state_reg.syncOne;
    state_next.toggleSeen = state_reg.syncTwo.sampleToggle;

    // Conversion phase: off, converting, or converged and in range.
    case (state_reg.phase)
      tts_pkg::TTS_OFF: begin
        if (state_reg.syncTwo.enable) begin
          state_next.phase = tts_pkg::TTS_CONVERT;
        end
      end
      tts_pkg::TTS_CONVERT: begin
        if (!state_reg.syncTwo.enable) begin
          state_next.phase = tts_pkg::TTS_OFF;
        end else if (sampleEdge && state_reg.syncTwo.converged &&
                     state_reg.syncTwo.inRange) begin
          state_next.phase = tts_pkg::TTS_VALID;
        end
      end
      tts_pkg::TTS_VALID: begin
        if (!state_reg.syncTwo.enable) begin
          state_next.phase = tts_pkg::TTS_OFF;
        end else if (!state_reg.syncTwo.converged ||
                     !state_reg.syncTwo.inRange) begin
          state_next.phase = tts_pkg::TTS_CONVERT;
        end
      end
      default: begin
        state_next.phase = tts_pkg::TTS_OFF;
      end
    endcase

    // Each conversion loads the adjusted count in straight binary.
    if (sampleEdge) begin
      state_next.count = applyOffset(state_reg.syncTwo.rawCount,
                                     state_reg.offset);
    end

    // Trip flags follow the current reading and limits.
    state_next.trips[`TTS_HOT_BIT] = tripAbove(phaseValid,
      state_reg.count, tripLimits.hot);
    state_next.trips[`TTS_AUX3_BIT] = tripAbove(phaseValid,
      state_reg.count, tripLimits.aux3);
    state_next.trips[`TTS_AUX2_BIT] = tripAbove(phaseValid,
      state_reg.count, tripLimits.aux2);
    state_next.trips[`TTS_AUX1_BIT] = tripAbove(phaseValid,
      state_reg.count, tripLimits.aux1);
    state_next.trips[`TTS_AUX0_BIT] = tripAbove(phaseValid,
      state_reg.count, tripLimits.aux0);
    state_next.trips[`TTS_CAT_BIT] = tripAbove(phaseValid,
      state_reg.count, tripLimits.catastrophic);

    // Only the offset register takes writes; the rest ignore them.
    if (busReq.write && (busReq.addr == `TTS_OFFSET_ADDR)) begin
      state_next.offset = busReq.wdata;
    end

    // Read answer one cycle after the request; unmapped reads give zero.
    state_next.rvalid = busReq.read;
    state_next.rdata = `TTS_BYTE_ZERO;
    if (busReq.read) begin
      case (busReq.addr)
        `TTS_STATUS_LO_ADDR: begin
          state_next.rdata = statusWord[7:0];
        end
        `TTS_STATUS_HI_ADDR: begin
          state_next.rdata = statusWord[15:8];
        end
        `TTS_COUNT_ADDR: begin
          state_next.rdata = state_reg.count;
        end
        `TTS_OFFSET_ADDR: begin
          state_next.rdata = state_reg.offset;
        end
        default: begin
          state_next.rdata = `TTS_BYTE_ZERO;
        end
      endcase
    end
  end

  // Registers the state; reset loads constants only.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_next_reset_block: begin
        state_reg.syncOne <= '0;
        state_reg.syncTwo <= '0;
        state_reg.toggleSeen <= 1'h0;
        state_reg.phase <= tts_pkg::TTS_OFF;
        state_reg.count <= `TTS_COUNT_RESET;
        state_reg.offset <= `TTS_OFFSET_RESET;
        state_reg.trips <= `TTS_TRIPS_ZERO;
        state_reg.rdata <= `TTS_BYTE_ZERO;
        state_reg.rvalid <= 1'h0;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state flip-flops, except status bit 10, which is decoded from the phase.
  assign busRsp.rdata = state_reg.rdata;
  assign busRsp.rvalid = state_reg.rvalid;
  assign thermalStatus = statusWord;
  assign thermometerCount = state_reg.count;

  // Checks run on clk and sleep during reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // The hot flag matches the reading and limit of the cycle before.
  hot_trip_a: assert property (
    state_reg.trips[`TTS_HOT_BIT] == ($past(phaseValid) &&
      ($past(state_reg.count) > $past(tripLimits.hot))))
    else $error("hot trip flag disagrees with reading");

  // The aux3 flag rises only on a valid reading above its limit.
  aux_three_a: assert property (
    $rose(state_reg.trips[`TTS_AUX3_BIT]) |->
      $past(phaseValid) && ($past(state_reg.count) > $past(tripLimits.aux3)))
    else $error("aux3 trip flag rose without cause");

  // The aux2 flag is clear whenever the prior reading was not above it.
  aux_two_a: assert property (
    !(phaseValid && (state_reg.count > tripLimits.aux2)) |=>
      !state_reg.trips[`TTS_AUX2_BIT])
    else $error("aux2 trip flag set without cause");

  // The aux1 flag is set after a valid reading above its limit.
  aux_one_a: assert property (
    (phaseValid && (state_reg.count > tripLimits.aux1)) |=>
      state_reg.trips[`TTS_AUX1_BIT])
    else $error("aux1 trip flag missed a trip");

  // All trip flags, aux0 among them, are clear right after reset.
  aux_zero_a: assert property (
    $past(reset) |-> state_reg.trips == `TTS_TRIPS_ZERO)
    else $error("trip flags not clear after reset");

  // The catastrophic flag matches the reading one cycle later.
  cat_trip_a: assert property (
    state_reg.trips[`TTS_CAT_BIT] == ($past(phaseValid) &&
      ($past(state_reg.count) > $past(tripLimits.catastrophic))))
    else $error("catastrophic trip flag disagrees with reading");

  // The reading changes only when a conversion arrives.
  count_change_a: assert property (
    $changed(state_reg.count) |-> $past(sampleEdge))
    else $error("reading changed without a conversion");

  // The reading is all ones right after reset.
  count_reset_a: assert property (
    $past(reset) |-> state_reg.count == `TTS_COUNT_RESET)
    else $error("reading not all ones after reset");

  // An offset write is stored in the offset register one cycle later.
  offset_write_a: assert property (
    (busReq.write && busReq.addr == `TTS_OFFSET_ADDR) |=>
      state_reg.offset == $past(busReq.wdata))
    else $error("offset write not stored");

  // A conversion loads raw count plus offset, clipped at the top.
  offset_apply_a: assert property (
    sampleEdge |=> state_reg.count ==
      applyOffset($past(state_reg.syncTwo.rawCount), $past(state_reg.offset)))
    else $error("reading not adjusted by the offset");

  // The valid flag drops within a cycle of the thermometer turning off.
  valid_off_a: assert property (
    !state_reg.syncTwo.enable |=> !statusWord[`TTS_VALID_BIT])
    else $error("valid flag stayed set while thermometer off");

  // The valid flag rises only on a converged in-range conversion.
  valid_rise_a: assert property (
    $rose(statusWord[`TTS_VALID_BIT]) |->
      $past(sampleEdge) && $past(state_reg.syncTwo.converged) &&
      $past(state_reg.syncTwo.inRange))
    else $error("valid flag rose without convergence");

  // Writes to the reading register leave it unchanged.
  ro_write_a: assert property (
    (busReq.write && busReq.addr == `TTS_COUNT_ADDR && !sampleEdge) |=>
      $stable(state_reg.count))
    else $error("write altered the read-only reading");

  // Every read is answered exactly one cycle later.
  read_answer_a: assert property (
    busReq.read |=> busRsp.rvalid)
    else $error("read not answered in one cycle");

  // Main scenarios worth seeing.
  valid_seen_c: cover property ($rose(statusWord[`TTS_VALID_BIT]));
  hot_seen_c: cover property ($rose(state_reg.trips[`TTS_HOT_BIT]));
  cat_seen_c: cover property ($rose(state_reg.trips[`TTS_CAT_BIT]));
  offset_then_sample_c: cover property (
    (busReq.write && busReq.addr == `TTS_OFFSET_ADDR) ##[1:20] sampleEdge);

endmodule
`default_nettype wire

// [verif/tts_thermal_readout_bench.sv]
// Self-checking bench for the thermal trip status readout.
`include "tts_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tts_thermal_readout_bench;
  logic clk;
  logic reset;
  tts_pkg::tts_bus_req_type busReq;
  tts_pkg::tts_bus_rsp_type busRsp;
  tts_pkg::tts_sensor_type sensorIn;
  tts_pkg::tts_threshold_type tripLimits;
  logic [15:0] thermalStatus;
  logic [7:0] thermometerCount;
  int failures;
  int n_checks;
  int cycles;
  int offsModel;
  int countModel;
  logic [15:0] statusModel;

  tts_thermal_readout dut_u (
    .clk(clk),
    .reset(reset),
    .busReq(busReq),
    .busRsp(busRsp),
    .sensorIn(sensorIn),
    .tripLimits(tripLimits),
    .thermalStatus(thermalStatus),
    .thermometerCount(thermometerCount)
  );

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("mismatch at %0t: run took too long", $time);
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Writes hold the strobe one cycle, then leave one idle cycle.
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    busReq.addr = a;
    busReq.wdata = d;
    busReq.write = 1'b1;
    tick();
    busReq.write = 1'b0;
    tick();
  endtask

  // The answer is due exactly one cycle after the read is taken.
  task automatic bus_rd(input logic [15:0] a, input logic [7:0] exp);
    busReq.addr = a;
    busReq.read = 1'b1;
    tick();
    busReq.read = 1'b0;
    chk({7'h00, busRsp.rvalid, busRsp.rdata}, {8'h01, exp}, "read");
    tick();
  endtask

  // Compares ports and every register against the model.
  task automatic check_all;
    chk(thermalStatus, statusModel, "status");
    chk({8'h00, thermometerCount}, {8'h00, 8'(countModel)}, "count");
    bus_rd(`TTS_STATUS_LO_ADDR, statusModel[7:0]);
    bus_rd(`TTS_STATUS_HI_ADDR, statusModel[15:8]);
    bus_rd(`TTS_COUNT_ADDR, 8'(countModel));
    bus_rd(`TTS_OFFSET_ADDR, 8'(offsModel));
  endtask

  // Runs one conversion and works out the expected reading and flags.
  task automatic convert(input logic [7:0] raw, input logic en,
                         input logic inr, input logic conv);
    bit v;
    sensorIn.rawCount = raw;
    sensorIn.enable = en;
    sensorIn.inRange = inr;
    sensorIn.converged = conv;
    repeat (4) tick();
    sensorIn.sampleToggle = ~sensorIn.sampleToggle;
    repeat (8) tick();
    countModel = int'(raw) + offsModel;
    if (countModel > 255) countModel = 255;
    v = en && inr && conv;
    statusModel = 16'h0000;
    statusModel[10] = v;
    for (int i = 0; i < 6; i++) begin
      statusModel[i] = v && (countModel > int'(tripLimits[8*i +: 8]));
    end
    check_all();
  endtask

  // Main sequence.
  initial begin
    reset = 1'b1;
    busReq = '0;
    sensorIn = '0;
    tripLimits = '0;
    void'($urandom(32'hF199));
    repeat (6) tick();
    reset = 1'b0;
    offsModel = 0;
    countModel = 255;
    statusModel = 16'h0000;
    check_all();
    $display("test reset values done");
    // Software programs the offset; read-only and unmapped writes vanish.
    bus_wr(`TTS_OFFSET_ADDR, 8'hA5);
    offsModel = 'hA5;
    bus_wr(`TTS_STATUS_LO_ADDR, 8'hFF);
    bus_wr(`TTS_STATUS_HI_ADDR, 8'hFF);
    bus_wr(`TTS_COUNT_ADDR, 8'h12);
    bus_wr(16'h1048, 8'h34);
    check_all();
    bus_rd(16'h1048, 8'h00);
    $display("test register access done");
    // Saturated reading, then limits equal to and one below it.
    bus_wr(`TTS_OFFSET_ADDR, 8'h10);
    offsModel = 'h10;
    tripLimits = {6{8'hFF}};
    convert(8'hF8, 1'b1, 1'b1, 1'b1);
    tripLimits = {6{8'hFE}};
    convert(8'hF8, 1'b1, 1'b1, 1'b1);
    convert(8'h20, 1'b0, 1'b1, 1'b1);
    $display("test boundaries done");
    // Random readings, offsets, limits and sensor states.
    for (int k = 0; k < 40; k++) begin
      if ($urandom % 3 == 0) begin
        offsModel = $urandom % 256;
        bus_wr(`TTS_OFFSET_ADDR, 8'(offsModel));
      end
      bus_wr(`TTS_COUNT_ADDR, 8'($urandom));
      tripLimits = tts_pkg::tts_threshold_type'({$urandom, $urandom});
      convert(8'($urandom), $urandom % 4 != 0, $urandom % 4 != 0,
              $urandom % 4 != 0);
    end
    $display("test random conversions done");
    wrap_up();
  end
endmodule
`default_nettype wire
